// ==== rtl/config_prom_readout.sv ====
/*
 * Memory end of the configuration read-out link: storage, address counter, serial or
 * parallel output drivers, cascade enable and open-drain reset.
 * One store byte goes out per clock rise in parallel mode, one bit in serial mode, and
 * the memory falls silent and lowers its cascade enable after the terminal unit.
 * Assumes configClock, chipEnableN and oeResetIn are synchronous to clk, and that the
 * configuration clock stays low for at least one clk between rises so that each rise
 * is seen once.
 * Assumes the surroundings resolve the open-drain reset line and the shared data lines.
 */
`timescale 1ns/1ps
module config_prom_readout #(
	parameter logic PARALLEL_MODE = 1'b0,
	parameter logic [7:0] INIT_SEED = 8'hA5
) (
	input wire logic clk,
	input wire logic rst_n,
	config_prom_if.memory link,
	input wire logic resetRequest
);

	// ----------------------------------------
	// Storage and stored width setting
	// ----------------------------------------
	logic [7:0] store [config_prom_pkg::DEPTH_BYTES];
	logic parallelSel;

	// Contents are a fixed pattern; programming is out of scope for this block.
	// Byte i holds i xor the seed, so every unit that goes out can be predicted.
	always_comb
	begin
		for (int i = 0; i < config_prom_pkg::DEPTH_BYTES; i++)
		begin
			store[i] = 8'(i) ^ INIT_SEED;
		end
	end

	// The width setting is fixed at build time, as a stored setting would be after programming.
	assign parallelSel = PARALLEL_MODE;

	// ----------------------------------------
	// Unit decoding
	// ----------------------------------------
	// The counter indexes bits in serial mode and bytes in parallel mode, so the byte that
	// holds the current unit sits at a different slice of the address in each mode.
	function automatic logic [5:0] unit_byte(input logic par, input logic [config_prom_pkg::ADDR_W-1:0] addr);
		if (par)
			return addr[5:0];
		return addr[8:3];
	endfunction : unit_byte

	// Serial data leaves each byte most significant bit first.
	function automatic logic [2:0] msb_first_bit(input logic [2:0] bitIndex);
		return 3'h7 - bitIndex;
	endfunction : msb_first_bit

	// Terminal address of the store for the selected unit width.
	function automatic logic [config_prom_pkg::ADDR_W-1:0] last_unit(input logic par);
		if (par)
			return config_prom_pkg::TERMINAL_COUNT_PARALLEL;
		return config_prom_pkg::TERMINAL_COUNT_SERIAL;
	endfunction : last_unit

	// ----------------------------------------
	// Address counter
	// ----------------------------------------
	logic clkPrev_q;
	logic inReset;
	logic enabled;
	logic risingEdge;
	logic atTerminal;
	logic pastTerminal_q;
	logic [config_prom_pkg::ADDR_W-1:0] addr_q;
	logic [config_prom_pkg::ADDR_W-1:0] addr_d;
	logic [config_prom_pkg::ADDR_W-1:0] terminalCount;

	// The memory's own reset request counts at once; its pull on the shared line is
	// registered and would otherwise leave one clk in which the counter still ran.
	assign inReset = ~link.oeResetIn | resetRequest;
	assign enabled = ~link.chipEnableN & ~inReset;
	assign risingEdge = link.configClock & ~clkPrev_q;
	assign terminalCount = last_unit(parallelSel);
	assign atTerminal = (addr_q == terminalCount);
	assign addr_d = addr_q + 12'h001;

	// The edge detector starts at the idle level of the configuration clock, so no
	// false rise is seen after reset.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clkPrev_q <= 1'b0;
		else
			clkPrev_q <= link.configClock;
	end

	// The counter stops at the terminal address rather than wrapping, so a long clock
	// burst cannot replay the start of the store onto lines that a later memory owns.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			addr_q <= config_prom_pkg::ADDR_ZERO;
		else if (!enabled)
			addr_q <= config_prom_pkg::ADDR_ZERO;
		else if (risingEdge && !pastTerminal_q && !atTerminal)
			addr_q <= addr_d;
	end

	// The rise that moves past the terminal address is the one that takes its last unit.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pastTerminal_q <= 1'b0;
		else if (!enabled)
			pastTerminal_q <= 1'b0;
		else if (risingEdge && atTerminal)
			pastTerminal_q <= 1'b1;
	end

	// ----------------------------------------
	// Output drivers
	// ----------------------------------------
	// Outputs are registered, so they settle one clk after the edge that moved the counter.
	// A floating pin shows zero on its data bit; only the enable tells it apart.
	logic [7:0] byteNow;
	logic bitNow;
	logic driving;
	logic [7:0] dataOut_q;
	logic [7:0] dataOe_q;
	logic ceo_q;
	logic odOe_q;

	assign byteNow = store[unit_byte(parallelSel, addr_q)];
	assign bitNow = byteNow[msb_first_bit(addr_q[2:0])];
	assign driving = enabled & ~pastTerminal_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dataOut_q <= config_prom_pkg::DATA_ZERO;
		else if (!driving)
			dataOut_q <= config_prom_pkg::DATA_ZERO;
		else if (parallelSel)
			dataOut_q <= byteNow;
		else
			dataOut_q <= {7'h00, bitNow};
	end

	// The enables share the data register stage, so no pin is ever enabled while it still
	// shows the idle zero from before the memory was enabled.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dataOe_q <= config_prom_pkg::DATA_ZERO;
		else if (!driving)
			dataOe_q <= config_prom_pkg::DATA_ZERO;
		else if (parallelSel)
			dataOe_q <= 8'hFF;
		else
			dataOe_q <= 8'h01;
	end

	// The cascade enable is low only after the terminal unit has gone out, and rises again
	// one clk after either control drops, handing the lines back in order.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ceo_q <= 1'b1;
		else
			ceo_q <= ~(enabled & pastTerminal_q);
	end

	// Limitation: only the memory's own request pulls the shared line; a low driven from
	// outside is obeyed but never stretched.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			odOe_q <= 1'b0;
		else
			odOe_q <= resetRequest;
	end

	// ----------------------------------------
	// Pin connections
	// ----------------------------------------
	// The open-drain pin only ever drives low; its level comes from the enable alone.
	assign link.dataOut = dataOut_q;
	assign link.dataOe = dataOe_q;
	assign link.cascadeEnableOutN = ceo_q;
	assign link.oeResetOut = 1'b0;
	assign link.oeResetOe = odOe_q;

endmodule : config_prom_readout

// ==== rtl/config_prom_pkg.sv ====
/*
 * Shared constants for the configuration memory read-out link: data width, address width,
 * storage depth and clock-rate limits.
 * Assumes both ends run from one system clock, clk, at 200 MHz.
 */
package config_prom_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int DEPTH_BYTES = 64;
	localparam logic [ADDR_W-1:0] TERMINAL_COUNT_SERIAL = 12'h01FF;
	localparam logic [ADDR_W-1:0] TERMINAL_COUNT_PARALLEL = 12'h003F;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam int CLK_MHZ = 200;
	localparam int CFG_CLK_MAX_MHZ = 33;
	localparam int CFG_CLK_HALF_CYCLES = (CLK_MHZ + 2 * CFG_CLK_MAX_MHZ - 1) / (2 * CFG_CLK_MAX_MHZ);
	localparam logic [7:0] HALF_CYCLES = 8'(CFG_CLK_HALF_CYCLES);
	localparam logic [15:0] COUNT_ONE = 16'h0001;

endpackage : config_prom_pkg

// ==== rtl/config_prom_if.sv ====
/*
 * Pins between a configuration memory and the configuration port that clocks it.
 * Assumes the bench resolves the open-drain reset line and the shared data lines from the enables.
 */
`timescale 1ns/1ps
interface config_prom_if;
	logic configClock;
	logic chipEnableN;
	logic oeResetIn;
	logic oeResetOut;
	logic oeResetOe;
	logic [7:0] dataOut;
	logic [7:0] dataOe;
	logic [7:0] dataIn;
	logic cascadeEnableOutN;

	modport memory (
		input configClock,
		input chipEnableN,
		input oeResetIn,
		output oeResetOut,
		output oeResetOe,
		output dataOut,
		output dataOe,
		output cascadeEnableOutN
	);

	modport loader (
		output configClock,
		output chipEnableN,
		input oeResetIn,
		output oeResetOut,
		output oeResetOe,
		input dataIn
	);
endinterface : config_prom_if

// ==== rtl/config_loader.sv ====
/*
 * Loader end: makes the configuration clock, enables the memory, and captures
 * a fixed number of bits or bytes.
 * Assumes the memory end drives data a few clk after each configuration clock rise.
 */
`timescale 1ns/1ps
module config_loader (
	input wire logic clk,
	input wire logic rst_n,
	config_prom_if.loader link,
	input wire logic start,
	input wire logic parallelMode,
	input wire logic [15:0] unitCount,
	output logic [7:0] captured,
	output logic capturedValid,
	output logic busy
);

	typedef enum logic [1:0] {IDLE, RUN, DONE} state_e;
	state_e state_q;
	logic [7:0] div_q;
	logic config_clock_q;
	logic primed_q;
	logic [15:0] left_q;
	logic [7:0] cap_q;
	logic capV_q;
	logic ceN_q;
	logic busy_q;

	// ----------------------------------------
	// Clock generation and capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= IDLE;
			div_q <= 8'h00;
			config_clock_q <= 1'b0;
			primed_q <= 1'b0;
			left_q <= 16'h0000;
			cap_q <= 8'h00;
			capV_q <= 1'b0;
			ceN_q <= 1'b1;
			busy_q <= 1'b0;
		end
		else
		begin
			capV_q <= 1'b0;
			case (state_q)
				IDLE:
				begin
					config_clock_q <= 1'b0;
					primed_q <= 1'b0;
					if (start && unitCount != 16'h0000)
					begin
						state_q <= RUN;
						left_q <= unitCount;
						div_q <= 8'h00;
						ceN_q <= 1'b0;
						busy_q <= 1'b1;
					end
				end
				RUN:
				begin
					if (div_q == config_prom_pkg::HALF_CYCLES - 8'h01)
					begin
						div_q <= 8'h00;
						config_clock_q <= ~config_clock_q;
						if (!config_clock_q)
						begin
							// the rise captures the value that the previous rise produced.
							primed_q <= 1'b1;
							cap_q <= parallelMode ? link.dataIn : {7'h00, link.dataIn[0]};
							capV_q <= 1'b1;
							left_q <= left_q - config_prom_pkg::COUNT_ONE;
							if (left_q == config_prom_pkg::COUNT_ONE)
							begin
								state_q <= DONE;
								busy_q <= 1'b0;
							end
						end
					end
					else
						div_q <= div_q + 8'h01;
				end
				DONE:
				begin
					config_clock_q <= 1'b0;
					if (!start)
					begin
						state_q <= IDLE;
						ceN_q <= 1'b1;
					end
				end
				default:
				begin
					state_q <= IDLE;
					ceN_q <= 1'b1;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	assign link.configClock = config_clock_q;
	assign link.chipEnableN = ceN_q;
	assign link.oeResetOut = 1'b0;
	assign link.oeResetOe = 1'b0;
	assign captured = cap_q;
	assign capturedValid = capV_q;
	assign busy = busy_q;

endmodule : config_loader

// ==== verif/config_prom_checker.sv ====
/* Assertions on the memory end pins of the read-out link, serial mode.
   Instantiated by the bench beside the link. */
`timescale 1ns/1ps
module config_prom_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic configClock,
	input wire logic chipEnableN,
	input wire logic oeResetIn,
	input wire logic [7:0] dataOut,
	input wire logic [7:0] dataOe,
	input wire logic cascadeEnableOutN
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_FLOAT_RESET: assert property (!oeResetIn |=> dataOe == 8'h00) else $error("driven in reset");
	AST_FLOAT_STANDBY: assert property (chipEnableN |=> dataOe == 8'h00) else $error("driven in standby");
	AST_SERIAL_UPPER: assert property (dataOe[7:1] == 7'h00) else $error("upper pin driven");
	AST_CEO_HIGH: assert property ((chipEnableN || !oeResetIn) |=> cascadeEnableOutN) else $error("ceo low");
	AST_CEO_CAUSE: assert property (!cascadeEnableOutN |-> !$past(chipEnableN) && $past(oeResetIn))
		else $error("ceo low without enable");
	AST_QUIET_PAST_TC: assert property (!cascadeEnableOutN |-> dataOe == 8'h00) else $error("driven past end");
	AST_DRIVE_ON_ENABLE: assert property (($fell(chipEnableN) && oeResetIn) ##1 (!chipEnableN && oeResetIn)
		|-> dataOe[0]) else $error("no data after enable");
	AST_MOVE_ON_RISE: assert property ((dataOe[0] && $past(dataOe[0]) && $changed(dataOut[0]))
		|-> ($past(configClock, 2) && !$past(configClock, 3))) else $error("data moved without rise");
	AST_CLOCK_RATE: assert property ($rose(configClock) |=> (!$rose(configClock))[*6])
		else $error("configuration clock too fast");
	cover property ($fell(cascadeEnableOutN));
	cover property ($fell(oeResetIn));
	cover property ($rose(dataOe[0]));
endmodule : config_prom_checker

// ==== verif/testbench.sv ====
/* Bench: a serial and a parallel pair of memory and loader, each on two link copies
   that the bench joins and resolves.
   Assumes a store of index xor seed, serial bits sent MSB first. */
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [15:0] units; logic ceoN;} row_s;
	localparam logic [7:0] SEED = 8'h3C;
	localparam logic [15:0] PAR_UNITS = 16'h0040;
	row_s rows [3] = '{'{16'h0001, 1'b1}, '{16'h0014, 1'b1}, '{16'h0200, 1'b0}};
	logic clk;
	logic rst_n;
	logic start;
	logic resetRequest;
	logic [15:0] unitCount;
	logic floatPat = 1'b0;
	logic parStart;
	logic [7:0] parCaptured;
	logic parValid;
	logic parBusy;
	logic parOeLine;
	logic oeLine;
	logic [7:0] captured;
	logic capturedValid;
	logic busy;
	int mismatches;
	int compares;
	config_prom_if memIf ();
	config_prom_if ldrIf ();
	config_prom_readout #(.PARALLEL_MODE(1'b0), .INIT_SEED(SEED)) i_config_prom_readout (.clk(clk),
		.rst_n(rst_n), .link(memIf.memory), .resetRequest(resetRequest));
	config_loader i_config_loader (.clk(clk), .rst_n(rst_n), .link(ldrIf.loader), .start(start), .parallelMode(1'b0),
		.unitCount(unitCount), .captured(captured), .capturedValid(capturedValid), .busy(busy));
	config_prom_checker i_config_prom_checker (.clk(clk), .rst_n(rst_n), .configClock(memIf.configClock),
		.chipEnableN(memIf.chipEnableN), .oeResetIn(memIf.oeResetIn), .dataOut(memIf.dataOut),
		.dataOe(memIf.dataOe), .cascadeEnableOutN(memIf.cascadeEnableOutN));
	// The reset line has a pull-up; data lines have none, so a floating pin toggles to stay unpredictable.
	assign oeLine = !(memIf.oeResetOe || ldrIf.oeResetOe);
	assign memIf.oeResetIn = oeLine;
	assign ldrIf.oeResetIn = oeLine;
	assign memIf.configClock = ldrIf.configClock;
	assign memIf.chipEnableN = ldrIf.chipEnableN;
	assign ldrIf.dataIn = (memIf.dataOut & memIf.dataOe) | (~memIf.dataOe & {8{floatPat}});
	config_prom_if parMemIf ();
	config_prom_if parLdrIf ();
	config_prom_readout #(.PARALLEL_MODE(1'b1), .INIT_SEED(SEED)) i_config_prom_readout_par (.clk(clk),
		.rst_n(rst_n), .link(parMemIf.memory), .resetRequest(resetRequest));
	config_loader i_config_loader_par (.clk(clk), .rst_n(rst_n), .link(parLdrIf.loader), .start(parStart),
		.parallelMode(1'b1), .unitCount(PAR_UNITS), .captured(parCaptured), .capturedValid(parValid),
		.busy(parBusy));
	assign parOeLine = !(parMemIf.oeResetOe || parLdrIf.oeResetOe);
	assign parMemIf.oeResetIn = parOeLine;
	assign parLdrIf.oeResetIn = parOeLine;
	assign parMemIf.configClock = parLdrIf.configClock;
	assign parMemIf.chipEnableN = parLdrIf.chipEnableN;
	assign parLdrIf.dataIn = (parMemIf.dataOut & parMemIf.dataOe) | (~parMemIf.dataOe & {8{floatPat}});

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic await_capture(input logic par);
		int t;
		t = 0;
		@(negedge clk);
		while ((par ? parValid : capturedValid) !== 1'b1 && t < 100)
		begin
			@(negedge clk);
			t++;
		end
		check({7'h00, (par ? parValid : capturedValid)}, 8'h01);
	endtask : await_capture

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end

	always @(negedge clk)
		floatPat <= !floatPat;

	initial
	begin
		#100000;
		mismatches++;
		conclude();
	end

	// ----------------
	// Stimulus
	// ----------------
	initial
	begin
		logic [7:0] e;
		rst_n = 1'b0;
		start = 1'b0;
		parStart = 1'b0;
		resetRequest = 1'b0;
		unitCount = 16'h0000;
		repeat (6) @(negedge clk);
		check({5'h00, memIf.dataOe[0], memIf.cascadeEnableOutN, ldrIf.chipEnableN}, 8'h03);
		check(parMemIf.dataOe, 8'h00);
		rst_n = 1'b1;
		$display("reset check done");
		foreach (rows[r])
		begin
			start = 1'b1;
			unitCount = rows[r].units;
			for (int k = 0; k < rows[r].units; k++)
			begin
				await_capture(1'b0);
				e = 8'(k >> 3) ^ SEED;
				check(captured, {7'h00, e[7 - (k & 7)]});
			end
			repeat (3) @(negedge clk);
			check({5'h00, busy, memIf.dataOe[0], memIf.cascadeEnableOutN},
				{6'h00, rows[r].ceoN, rows[r].ceoN});
			start = 1'b0;
			repeat (4) @(negedge clk);
			check({6'h00, memIf.dataOe[0], memIf.cascadeEnableOutN}, 8'h01);
			$display("row %0d done", r);
		end
		parStart = 1'b1;
		for (int k = 0; k < 64; k++)
		begin
			await_capture(1'b1);
			check(parCaptured, 8'(k) ^ SEED);
			check(parMemIf.dataOe, 8'hFF);
		end
		repeat (3) @(negedge clk);
		check({5'h00, parBusy, parMemIf.dataOe[0], parMemIf.cascadeEnableOutN}, 8'h00);
		parStart = 1'b0;
		repeat (4) @(negedge clk);
		check(parMemIf.dataOe, 8'h00);
		check({7'h00, parMemIf.cascadeEnableOutN}, 8'h01);
		$display("parallel done");
		start = 1'b1;
		unitCount = 16'h0010;
		repeat (30) @(negedge clk);
		resetRequest = 1'b1;
		repeat (2) @(negedge clk);
		check({6'h00, oeLine, memIf.dataOe[0]}, 8'h00);
		resetRequest = 1'b0;
		start = 1'b0;
		$display("reset request done");
		conclude();
	end
endmodule : testbench
